/* File: bench/asp_chipset_model.sv */
// chipset side: drives the two active-low sleep requests
`timescale 1ns/1ps
`default_nettype none

module asp_chipset_model (
  input wire logic clk_i,
  output logic suspend_ram_req_n_o,
  output logic soft_off_req_n_o
);
  initial begin
    suspend_ram_req_n_o = 1'b1;
    soft_off_req_n_o = 1'b1;
  end

  // soft-off low with suspend high is never offered here
  task automatic drive(input logic ram_n, input logic off_n);
    @(posedge clk_i);
    suspend_ram_req_n_o <= ram_n;
    soft_off_req_n_o <= off_n | ram_n;
  endtask : drive

  // low pulse on one line from the idle-high state; soft-off here is deliberate misuse
  task automatic pulse(input bit off_line, input int width);
    @(posedge clk_i);
    if (off_line) begin
      soft_off_req_n_o <= 1'b0;
    end else begin
      suspend_ram_req_n_o <= 1'b0;
    end
    repeat (width) @(posedge clk_i);
    soft_off_req_n_o <= 1'b1;
    suspend_ram_req_n_o <= 1'b1;
  endtask : pulse
endmodule : asp_chipset_model

`default_nettype wire

/* File: bench/asp_sequencer_bench.sv */
// self-checking bench for the sleep power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end

module asp_sequencer_bench;
  localparam int unsigned DGL = 4;
  localparam int unsigned SLP = 20;
  localparam int unsigned ACT = 50;
  localparam int unsigned RAMP = 10;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, suspend_ram_req_n_i, soft_off_req_n_i, active_gate_release_o;
  logic main_three_uv_i = 1'b1, ot_warn_i = 1'b0, ot_shut_i = 1'b0, ss_low_i = 1'b0;
  logic vid_supply_good_o, fault_o;
  asp_pkg::asp_rail_t uv_i = '0;
  asp_pkg::asp_rail_t rail_en_o;
  asp_pkg::asp_rail_t alt_rail_en;
  int error_cnt = 0;
  int compares = 0;
  // model state: 0 active, 1 suspend to ram, 2 soft off
  int mst = 0;
  logic [3:0] exp_r [3] = '{4'h7, 4'hE, 4'h6};
  logic [3:0] exp_m [3] = '{4'hF, 4'hF, 4'hF};

  always #5 clk_i = ~clk_i;

  asp_sequencer #(.ALT_FIVE_KEEP(1'b0), .DGL_CYC(DGL), .SLP_CYC(SLP), .WAIT_CYC(30),
    .ACT_CYC(ACT), .RAMP_CYC(RAMP)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .suspend_ram_req_n_i(suspend_ram_req_n_i), .soft_off_req_n_i(soft_off_req_n_i),
    .main_three_uv_i(main_three_uv_i), .uv_i(uv_i), .ot_warn_i(ot_warn_i),
    .ot_shut_i(ot_shut_i), .ss_low_i(ss_low_i), .rail_en_o(rail_en_o),
    .active_gate_release_o(active_gate_release_o), .vid_supply_good_o(vid_supply_good_o),
    .fault_o(fault_o));

  // alternate build keeps dual 5 V in soft-off; it shares every input with i_dut
  asp_sequencer #(.ALT_FIVE_KEEP(1'b1), .DGL_CYC(DGL), .SLP_CYC(SLP), .WAIT_CYC(30),
    .ACT_CYC(ACT), .RAMP_CYC(RAMP)) i_alt (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(),
    .suspend_ram_req_n_i(suspend_ram_req_n_i), .soft_off_req_n_i(soft_off_req_n_i),
    .main_three_uv_i(main_three_uv_i), .uv_i(uv_i), .ot_warn_i(ot_warn_i),
    .ot_shut_i(ot_shut_i), .ss_low_i(ss_low_i), .rail_en_o(alt_rail_en),
    .active_gate_release_o(), .vid_supply_good_o(), .fault_o());

  asp_chipset_model i_host (.clk_i(clk_i), .suspend_ram_req_n_o(suspend_ram_req_n_i),
    .soft_off_req_n_o(soft_off_req_n_i));

  // ---------------------------------------------------------------
  // bus and check helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
      input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    `CHK(n, 2)
  endtask : wb

  task automatic chk_state();
    `CHK(rail_en_o & exp_m[mst], exp_r[mst])
    `CHK(active_gate_release_o, mst == 0)
  endtask : chk_state

  // bounded wait for gate release; checks the timeout lower bound
  task automatic wait_gate();
    int n;
    n = 0;
    while (active_gate_release_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n >= ACT && n < 400, 1'b1)
    cyc(RAMP + 4);
  endtask : wait_gate

  task automatic do_reset();
    rst_i <= 1'b1;
    cyc(3);
    rst_i <= 1'b0;
    mst = 0;
    cyc(2);
    `CHK(rail_en_o, 4'h6)
  endtask : do_reset

  task automatic wrap_up();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // whole run is about a thousand cycles; thirty times that is a hang
  initial begin
    #300000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    void'($urandom(11415));
    do_reset();
    cyc(60);
    `CHK(active_gate_release_o, 1'b0)
    main_three_uv_i <= 1'b0;
    wait_gate();
    chk_state();
    `CHK(vid_supply_good_o, 1'b1)
    wb(1'b0, `ASP_STAT_OFS, 4'hF, 32'h0);
    `CHK(rd, {16'h0, 4'h1, 3'b011, asp_pkg::SQ_RUN, asp_pkg::PS_ACTIVE})
    wb(1'b0, `ASP_CTRL_OFS, 4'hF, 32'h0);
    `CHK(rd, {31'h0, `ASP_CTRL_RST})
    for (int i = 0; i < 4; i++) begin
      i_host.pulse(1'b0, 1 + ($urandom % (DGL - 1)));
      wb(1'b0, `ASP_STAT_OFS, 4'hF, 32'h0);
      `CHK(rd[`ASP_STAT_RAM_BIT], 1'b1)
    end
    i_host.pulse(1'b1, SLP + 2 * DGL);
    cyc(SLP);
    chk_state();
    for (int k = 1; k < 3; k++) begin
      i_host.drive(1'b0, k == 1);
      cyc(DGL + SLP - 4);
      `CHK(active_gate_release_o, 1'b1)
      cyc(12);
      mst = k;
      chk_state();
      `CHK(alt_rail_en.dual_five_out, 1'b1)
      i_host.drive(1'b0, k != 1);
      cyc(SLP + 3 * DGL);
      chk_state();
      i_host.drive(1'b1, 1'b1);
      mst = 0;
      wait_gate();
      chk_state();
    end
    for (int j = 0; j < 2; j++) begin
      uv_i <= 4'h8 >> j;
      cyc(3);
      `CHK(fault_o, 1'b1)
      chk_state();
      uv_i <= '0;
      cyc(3);
      `CHK(fault_o, 1'b0)
    end
    uv_i <= 4'h1;
    cyc(3);
    `CHK(vid_supply_good_o, 1'b0)
    uv_i <= '0;
    cyc(3);
    `CHK({rail_en_o.vid_supply_out, active_gate_release_o, fault_o}, 3'b011)
    ss_low_i <= 1'b1;
    cyc(4);
    `CHK({rail_en_o, active_gate_release_o, fault_o}, 6'h0)
    ss_low_i <= 1'b0;
    cyc(3);
    `CHK(rail_en_o, 4'h6)
    wait_gate();
    chk_state();
    main_three_uv_i <= 1'b1;
    cyc(20);
    mst = 2;
    chk_state();
    `CHK(fault_o, 1'b1)
    `CHK(alt_rail_en.dual_five_out, 1'b1)
    main_three_uv_i <= 1'b0;
    cyc(3);
    `CHK(fault_o, 1'b0)
    mst = 0;
    wait_gate();
    chk_state();
    wb(1'b1, `ASP_CTRL_OFS, 4'h0, 32'h1);
    wb(1'b1, 8'h10, 4'hF, $urandom);
    `CHK(active_gate_release_o, 1'b1)
    wb(1'b1, `ASP_CTRL_OFS, 4'hF, 32'h1);
    cyc(3);
    `CHK({rail_en_o, fault_o}, 5'h0)
    wb(1'b0, 8'h10, 4'hF, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, `ASP_CTRL_OFS, 4'hF, 32'h0);
    `CHK(rd, 32'h1)
    wb(1'b1, `ASP_CTRL_OFS, 4'hF, 32'h0);
    wait_gate();
    ot_warn_i <= 1'b1;
    cyc(3);
    `CHK({active_gate_release_o, fault_o}, 2'b11)
    ot_warn_i <= 1'b0;
    ot_shut_i <= 1'b1;
    cyc(1);
    ot_shut_i <= 1'b0;
    cyc(20);
    `CHK({rail_en_o, active_gate_release_o, fault_o}, 6'h1)
    do_reset();
    cyc(RAMP + 3);
    uv_i <= 4'h2;
    cyc(3);
    uv_i <= '0;
    cyc(20);
    `CHK({rail_en_o, fault_o}, 5'h1)
    ss_low_i <= 1'b1;
    cyc(3);
    ss_low_i <= 1'b0;
    cyc(20);
    `CHK(rail_en_o, 4'h0)
    do_reset();
    wrap_up();
  end
endmodule : asp_sequencer_bench

bind asp_sequencer asp_sequencer_monitor #(.ACT_CYC(ACT_CYC)) i_mon (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .suspend_ram_req_n_i(suspend_ram_req_n_i),
  .soft_off_req_n_i(soft_off_req_n_i), .main_three_uv_i(main_three_uv_i), .uv_i(uv_i),
  .ot_warn_i(ot_warn_i), .ot_shut_i(ot_shut_i), .ss_low_i(ss_low_i), .rail_en_o(rail_en_o),
  .active_gate_release_o(active_gate_release_o), .vid_supply_good_o(vid_supply_good_o),
  .fault_o(fault_o));

`default_nettype wire

/* File: bench/asp_sequencer_monitor.sv */
// port checker for the sleep power sequencer
`timescale 1ns/1ps
`default_nettype none

module asp_sequencer_monitor #(
  parameter int unsigned ACT_CYC = 50
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic suspend_ram_req_n_i,
  input wire logic soft_off_req_n_i,
  input wire logic main_three_uv_i,
  input wire asp_pkg::asp_rail_t uv_i,
  input wire logic ot_warn_i,
  input wire logic ot_shut_i,
  input wire logic ss_low_i,
  input wire asp_pkg::asp_rail_t rail_en_o,
  input wire logic active_gate_release_o,
  input wire logic vid_supply_good_o,
  input wire logic fault_o
);
  // edges the main input has stayed good, saturating at the timeout
  int unsigned good_cnt_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i || main_three_uv_i) begin
      good_cnt_ff <= 0;
    end else if (good_cnt_ff < ACT_CYC) begin
      good_cnt_ff <= good_cnt_ff + 1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_power_on_ramp: assert property (
    $fell(rst_i) && !ss_low_i |=> rail_en_o == 4'h6 && !active_gate_release_o)
    else $error("first ramp missing after reset");
  a_gate_with_vid: assert property (
    $rose(active_gate_release_o) |-> rail_en_o.vid_supply_out && good_cnt_ff == ACT_CYC)
    else $error("gate release without vid or early");
  a_vid_only_active: assert property (rail_en_o.vid_supply_out |-> active_gate_release_o)
    else $error("vid on outside active");
  a_halt_all_off: assert property (
    ss_low_i ##1 ss_low_i |=> rail_en_o == 4'h0 && !active_gate_release_o && !fault_o)
    else $error("soft-start low did not shut down");
  a_ext_uv_report: assert property (
    active_gate_release_o && !ss_low_i && (uv_i.dual_three_out || uv_i.dual_five_out)
    |-> ##[1:2] (fault_o && active_gate_release_o))
    else $error("external rail undervoltage mishandled");
  a_vid_good_low: assert property (uv_i.vid_supply_out |=> !vid_supply_good_o)
    else $error("vid good high under undervoltage");
  a_main_loss_off: assert property (
    active_gate_release_o && main_three_uv_i && !ss_low_i
    |-> ##[1:3] (fault_o && !active_gate_release_o))
    else $error("main input loss not forced off");
  a_warn_fault: assert property (ot_warn_i && !ss_low_i |=> fault_o)
    else $error("overtemp warning not reported");
  a_ot_shut_off: assert property (
    ot_shut_i |-> ##2 (rail_en_o == 4'h0 && !active_gate_release_o && fault_o) [*8])
    else $error("overtemp shutdown not held");

  c_gate_up: cover property ($rose(active_gate_release_o));
  c_halt: cover property (ss_low_i ##1 ss_low_i);
  c_vid_latched: cover property (active_gate_release_o && !rail_en_o.vid_supply_out);
endmodule : asp_sequencer_monitor

`default_nettype wire

/* File: hw/asp_sequencer.sv */
// sleep-state decode, rail sequencing and fault logic of the power controller
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

module asp_sequencer #(
  parameter bit ALT_FIVE_KEEP = 1'b0,
  parameter int unsigned DGL_CYC = `ASP_DGL_CYC,
  parameter int unsigned SLP_CYC = `ASP_SLP_CYC,
  parameter int unsigned WAIT_CYC = `ASP_WAIT_CYC,
  parameter int unsigned ACT_CYC = `ASP_ACT_CYC,
  parameter int unsigned RAMP_CYC = `ASP_RAMP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic suspend_ram_req_n_i,
  input wire logic soft_off_req_n_i,
  input wire logic main_three_uv_i,
  input wire asp_pkg::asp_rail_t uv_i,
  input wire logic ot_warn_i,
  input wire logic ot_shut_i,
  input wire logic ss_low_i,
  output asp_pkg::asp_rail_t rail_en_o,
  output logic active_gate_release_o,
  output logic vid_supply_good_o,
  output logic fault_o
);

  localparam int CW = 22;
  localparam logic [CW-1:0] DGL_TC = CW'(DGL_CYC - 1);
  localparam logic [CW-1:0] SLP_TC = CW'(SLP_CYC - 1);
  localparam logic [CW-1:0] WAIT_TC = CW'(WAIT_CYC - 1);
  localparam logic [CW-1:0] ACT_TC = CW'(ACT_CYC - 1);
  localparam logic [CW-1:0] RAMP_TC = CW'(RAMP_CYC - 1);

  // ----------------------------------------------------------------------------
  // request deglitch
  // ----------------------------------------------------------------------------
  logic [1:0] req_raw;
  logic [1:0] req_filt;
  logic ram_f;
  logic off_f;

  assign req_raw = {soft_off_req_n_i, suspend_ram_req_n_i};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dgl
      logic [CW-1:0] cnt_ff;
      logic filt_ff;
      // inputs idle high through pull-ups, so the filter starts high
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_ff <= '0;
          filt_ff <= 1'b1;
        end else if (req_raw[g] == filt_ff) begin
          cnt_ff <= '0;
        end else if (cnt_ff == DGL_TC) begin
          cnt_ff <= '0;
          filt_ff <= req_raw[g];
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
      assign req_filt[g] = filt_ff;
    end
  endgenerate

  assign ram_f = req_filt[0];
  assign off_f = req_filt[1];

  // ----------------------------------------------------------------------------
  // shared state
  // ----------------------------------------------------------------------------
  asp_pkg::asp_pstate_t pstate_ff;
  asp_pkg::asp_seq_t seq_ff;
  logic [CW-1:0] slp_cnt_ff;
  logic [CW-1:0] seq_cnt_ff;
  logic [CW-1:0] act_cnt_ff;
  logic [CW-1:0] vid_cnt_ff;
  logic forced_ff;
  logic act_ok_ff;
  logic vid_arm_ff;
  logic sb_lat_ff;
  logic vid_lat_ff;
  logic ctrl_shut_ff;
  logic halt;
  logic on;
  logic late;
  logic arm_base;
  logic arm_five;
  logic early_uv;
  logic uv_flag;

  // software shutdown acts exactly like the soft-start node held low
  assign halt = ss_low_i | ctrl_shut_ff;
  assign on = (seq_ff == asp_pkg::SQ_RAMP1) || (seq_ff == asp_pkg::SQ_WAIT) ||
              (seq_ff == asp_pkg::SQ_RAMP2) || (seq_ff == asp_pkg::SQ_RUN);
  assign late = (seq_ff == asp_pkg::SQ_RAMP2) || (seq_ff == asp_pkg::SQ_RUN);
  assign arm_base = on && (seq_ff != asp_pkg::SQ_RAMP1);
  assign arm_five = (seq_ff == asp_pkg::SQ_RUN) &&
                    (rail_en_o.dual_five_out || active_gate_release_o);
  assign early_uv = !halt && ((seq_ff == asp_pkg::SQ_WAIT) || (seq_ff == asp_pkg::SQ_RAMP2)) &&
                    (uv_i.dual_three_out || uv_i.standby_one_five_out);

  // ----------------------------------------------------------------------------
  // sleep-state decode
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pstate_ff <= asp_pkg::PS_ACTIVE;
      slp_cnt_ff <= '0;
      forced_ff <= 1'b0;
    end else if (forced_ff) begin
      slp_cnt_ff <= '0;
      if (!main_three_uv_i || halt) begin
        forced_ff <= 1'b0;
        pstate_ff <= asp_pkg::PS_ACTIVE;
      end
    end else begin
      case (pstate_ff)
        asp_pkg::PS_ACTIVE: begin
          if (act_ok_ff && main_three_uv_i) begin
            forced_ff <= 1'b1;
            pstate_ff <= asp_pkg::PS_SOFTOFF;
            slp_cnt_ff <= '0;
          end else if (ram_f) begin
            slp_cnt_ff <= '0;
          end else if (slp_cnt_ff == SLP_TC) begin
            slp_cnt_ff <= '0;
            pstate_ff <= off_f ? asp_pkg::PS_SUSPEND : asp_pkg::PS_SOFTOFF;
          end else begin
            slp_cnt_ff <= slp_cnt_ff + 1'b1;
          end
        end
        asp_pkg::PS_SUSPEND: begin
          // suspend to soft-off is refused; only wake is accepted
          if (ram_f && off_f) begin
            pstate_ff <= asp_pkg::PS_ACTIVE;
          end
        end
        asp_pkg::PS_SOFTOFF: begin
          // suspend-only request from soft-off is refused as well
          if (ram_f && off_f) begin
            pstate_ff <= asp_pkg::PS_ACTIVE;
          end
        end
        default: begin
          pstate_ff <= asp_pkg::PS_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // soft-start sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_ff <= asp_pkg::SQ_RAMP1;
      seq_cnt_ff <= '0;
    end else if (seq_ff != asp_pkg::SQ_LATCH && (ot_shut_i || early_uv)) begin
      seq_ff <= asp_pkg::SQ_LATCH;
      seq_cnt_ff <= '0;
    end else begin
      case (seq_ff)
        asp_pkg::SQ_LATCH: begin
          seq_ff <= asp_pkg::SQ_LATCH;
        end
        asp_pkg::SQ_HALT: begin
          seq_cnt_ff <= '0;
          if (!halt) begin
            seq_ff <= asp_pkg::SQ_RAMP1;
          end
        end
        asp_pkg::SQ_RAMP1: begin
          if (halt) begin
            seq_ff <= asp_pkg::SQ_HALT;
            seq_cnt_ff <= '0;
          end else if (seq_cnt_ff == RAMP_TC) begin
            seq_ff <= asp_pkg::SQ_WAIT;
            seq_cnt_ff <= '0;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 1'b1;
          end
        end
        asp_pkg::SQ_WAIT: begin
          if (halt) begin
            seq_ff <= asp_pkg::SQ_HALT;
            seq_cnt_ff <= '0;
          end else if (seq_cnt_ff == WAIT_TC) begin
            seq_ff <= asp_pkg::SQ_RAMP2;
            seq_cnt_ff <= '0;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 1'b1;
          end
        end
        asp_pkg::SQ_RAMP2: begin
          if (halt) begin
            seq_ff <= asp_pkg::SQ_HALT;
            seq_cnt_ff <= '0;
          end else if (seq_cnt_ff == RAMP_TC) begin
            seq_ff <= asp_pkg::SQ_RUN;
            seq_cnt_ff <= '0;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 1'b1;
          end
        end
        asp_pkg::SQ_RUN: begin
          if (halt) begin
            seq_ff <= asp_pkg::SQ_HALT;
          end
        end
        default: begin
          seq_ff <= asp_pkg::SQ_LATCH;
          seq_cnt_ff <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // active-state timeout and vid ramp
  // ----------------------------------------------------------------------------
  // restarts whenever the main input drops, so a glitchy supply never half-enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_cnt_ff <= '0;
      act_ok_ff <= 1'b0;
    end else if (pstate_ff != asp_pkg::PS_ACTIVE || forced_ff || halt || !arm_base ||
                 (main_three_uv_i && !act_ok_ff)) begin
      act_cnt_ff <= '0;
      act_ok_ff <= 1'b0;
    end else if (!act_ok_ff) begin
      if (act_cnt_ff == ACT_TC) begin
        act_ok_ff <= 1'b1;
      end else begin
        act_cnt_ff <= act_cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vid_cnt_ff <= '0;
      vid_arm_ff <= 1'b0;
    end else if (!rail_en_o.vid_supply_out) begin
      vid_cnt_ff <= '0;
      vid_arm_ff <= 1'b0;
    end else if (!vid_arm_ff) begin
      if (vid_cnt_ff == RAMP_TC) begin
        vid_arm_ff <= 1'b1;
      end else begin
        vid_cnt_ff <= vid_cnt_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // internal regulator latch-off
  // ----------------------------------------------------------------------------
  // set outranks clear; both can meet on the first halted cycle, before the monitors disarm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sb_lat_ff <= 1'b0;
    end else if (arm_base && rail_en_o.standby_one_five_out && uv_i.standby_one_five_out) begin
      sb_lat_ff <= 1'b1;
    end else if (halt) begin
      sb_lat_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vid_lat_ff <= 1'b0;
    end else if (vid_arm_ff && uv_i.vid_supply_out) begin
      vid_lat_ff <= 1'b1;
    end else if (halt) begin
      vid_lat_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  // dual 3.3 V and dual 5 V monitors only flag once running (dual 3.3 V low in wait or second ramp latches off): those rails pass externally
  assign uv_flag = (arm_base && uv_i.dual_three_out) ||
                   (arm_five && uv_i.dual_five_out) ||
                   sb_lat_ff || vid_lat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rail_en_o <= '0;
      active_gate_release_o <= 1'b0;
      vid_supply_good_o <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      rail_en_o.dual_three_out <= on;
      rail_en_o.standby_one_five_out <= on && !sb_lat_ff;
      rail_en_o.dual_five_out <= on && late && !halt &&
                                 ((pstate_ff == asp_pkg::PS_SUSPEND) ||
                                  ((pstate_ff == asp_pkg::PS_SOFTOFF) && ALT_FIVE_KEEP));
      rail_en_o.vid_supply_out <= on && !halt && act_ok_ff && !vid_lat_ff;
      active_gate_release_o <= on && !halt && act_ok_ff;
      vid_supply_good_o <= vid_arm_ff && !uv_i.vid_supply_out;
      fault_o <= !halt && (uv_flag || ot_warn_i || forced_ff || early_uv ||
                           seq_ff == asp_pkg::SQ_LATCH);
    end
  end

  // ----------------------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------------------
  logic req;
  logic [31:0] rd_data;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `ASP_CTRL_OFS: begin
        rd_data[`ASP_CTRL_SHUT_BIT] = ctrl_shut_ff;
      end
      `ASP_STAT_OFS: begin
        rd_data[`ASP_STAT_PST_MSB:`ASP_STAT_PST_LSB] = pstate_ff;
        rd_data[`ASP_STAT_SEQ_MSB:`ASP_STAT_SEQ_LSB] = seq_ff;
        rd_data[`ASP_STAT_RAM_BIT] = ram_f;
        rd_data[`ASP_STAT_OFF_BIT] = off_f;
        rd_data[`ASP_STAT_FORCED_BIT] = forced_ff;
        rd_data[`ASP_STAT_ACTOK_BIT] = act_ok_ff;
        rd_data[`ASP_STAT_SBLAT_BIT] = sb_lat_ff;
        rd_data[`ASP_STAT_VIDLAT_BIT] = vid_lat_ff;
        rd_data[`ASP_STAT_FAULT_BIT] = fault_o;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // unmapped addresses still ack, reading zero and ignoring writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // write lands on the edge where the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_shut_ff <= `ASP_CTRL_RST;
    end else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `ASP_CTRL_OFS) begin
      ctrl_shut_ff <= wb_dat_i[`ASP_CTRL_SHUT_BIT];
    end
  end

endmodule : asp_sequencer

`default_nettype wire

/* File: shared/asp_defines.svh */
// offsets, field positions, reset values and timing counts of the sleep power sequencer
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// ----------------------------------------------------------------------------
// register map (byte addresses on the wishbone bus)
// ----------------------------------------------------------------------------
`define ASP_CTRL_OFS 8'h00
`define ASP_STAT_OFS 8'h04
`define ASP_CTRL_RST 1'b0
`define ASP_CTRL_SHUT_BIT 0
`define ASP_STAT_PST_LSB 0
`define ASP_STAT_PST_MSB 2
`define ASP_STAT_SEQ_LSB 3
`define ASP_STAT_SEQ_MSB 8
`define ASP_STAT_RAM_BIT 9
`define ASP_STAT_OFF_BIT 10
`define ASP_STAT_FORCED_BIT 11
`define ASP_STAT_ACTOK_BIT 12
`define ASP_STAT_SBLAT_BIT 13
`define ASP_STAT_VIDLAT_BIT 14
`define ASP_STAT_FAULT_BIT 15

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ASP_CLK_MHZ 100
`define ASP_DGL_NS 2000
`define ASP_DGL_CYC ((`ASP_DGL_NS * `ASP_CLK_MHZ + 999) / 1000)
`define ASP_SLP_US 200
`define ASP_SLP_CYC (`ASP_SLP_US * `ASP_CLK_MHZ)
`define ASP_WAIT_US 3000
`define ASP_WAIT_CYC (`ASP_WAIT_US * `ASP_CLK_MHZ)
`define ASP_ACT_US 25000
`define ASP_ACT_CYC (`ASP_ACT_US * `ASP_CLK_MHZ)
`define ASP_RAMP_US 1000
`define ASP_RAMP_CYC (`ASP_RAMP_US * `ASP_CLK_MHZ)

`endif

/* File: shared/asp_pkg.sv */
// types shared by the sleep power sequencer
`default_nettype none

package asp_pkg;

  // ----------------------------------------------------------------------------
  // sleep decode and rail sequencing states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PS_ACTIVE = 3'b001,
    PS_SUSPEND = 3'b010,
    PS_SOFTOFF = 3'b100
  } asp_pstate_t;

  typedef enum logic [5:0] {
    SQ_RAMP1 = 6'b000001,
    SQ_WAIT = 6'b000010,
    SQ_RAMP2 = 6'b000100,
    SQ_RUN = 6'b001000,
    SQ_HALT = 6'b010000,
    SQ_LATCH = 6'b100000
  } asp_seq_t;

  // one bit per supply output, used for monitors and enables alike
  typedef struct packed {
    logic dual_five_out;
    logic dual_three_out;
    logic standby_one_five_out;
    logic vid_supply_out;
  } asp_rail_t;

endpackage : asp_pkg

`default_nettype wire
